// [ssp_map.svh]
// constants of the synthesizer serial programming port
//****************************************************************
// Operation
//****************************************************************
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

//****************************************************************
// word layout
//****************************************************************
`define SSP_WORD_BITS     16
`define SSP_ADDR_BITS     4
`define SSP_DATA_BITS     12
`define SSP_ADDR_MSB      15
`define SSP_ADDR_LSB      12
`define SSP_DATA_MSB      11
`define SSP_CNT_BITS      5
`define SSP_CNT_MAX       5'h1F
`define SSP_MOD_MIN_BITS  5'h02
`define SSP_MOD_MAX_BITS  5'h0C
`define SSP_FULL_BITS     5'h10
`define SSP_MOD_DATA_ADDR 4'h5

//****************************************************************
// reset values and synchroniser
//****************************************************************
`define SSP_SYNC_BITS     15
`define SSP_SYNC_RESET    15'h0001
`define SSP_SR_RESET      16'h0000
`define SSP_DATA_RESET    12'h000
`define SSP_ADDR_RESET    4'h0

`endif

// [ssp_pkg.sv]
// types of the synthesizer serial programming port
package ssp_pkg;

  // monitor source codes
  typedef enum logic [2:0] {
    SSP_MON_OSC      = 3'b000,
    SSP_MON_REF_AUX  = 3'b001,
    SSP_MON_REF_MAIN = 3'b010,
    SSP_MON_PD_AUX   = 3'b011,
    SSP_MON_PD_MAIN  = 3'b100,
    SSP_MON_LOOPBACK = 3'b101,
    SSP_MON_TEST     = 3'b110,
    SSP_MON_UNUSED   = 3'b111
  } ssp_mon_sel_type;

  // lock pin function
  typedef enum logic {
    SSP_LD_LOCK  = 1'b0,
    SSP_LD_STEER = 1'b1
  } ssp_ld_mode_type;

endpackage : ssp_pkg

// [ssp_sync.sv]
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module ssp_sync #(
  parameter int                W          = 1,
  parameter logic [W-1:0]      RESET_VAL  = '0
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // asynchronous in, filtered out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      s2_reg   <= RESET_VAL;
      s3_reg   <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      s2_reg   <= meta_reg;
      s3_reg   <= s2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_out <= RESET_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule : ssp_sync

// [ssp_port.sv]
// serial programming port, monitor output and lock/steer pins
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_port
  import ssp_pkg::*;
(
  // core clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // serial link from the host
  input  wire logic                        link_sclk,
  input  wire logic                        link_cs_n,
  input  wire logic                        link_data,
  input  wire logic                        link_mod,
  // configuration
  input  wire logic                        mod_addr_off,
  input  wire logic                        mod_src_sel,
  input  wire logic [2:0]                  mon_sel,
  input  wire logic                        mon_tristate,
  input  wire logic [1:0]                  ld_mode,
  // internal clocks for the monitor
  input  wire logic                        osc_clk,
  input  wire logic                        ref_aux_clk,
  input  wire logic                        ref_main_clk,
  input  wire logic                        secondary_compare_clock,
  input  wire logic                        primary_compare_clock,
  // loop status, index 0 primary, 1 secondary
  input  wire logic [1:0]                  lock_err,
  input  wire logic [1:0]                  steer_up,
  input  wire logic [1:0]                  steer_dn,
  // committed register writes
  output logic                             cfg_wr,
  output logic [`SSP_ADDR_BITS-1:0]        cfg_addr,
  output logic [`SSP_DATA_BITS-1:0]        cfg_data,
  // modulation samples
  output logic                             mod_valid,
  output logic signed [`SSP_DATA_BITS-1:0] mod_sample,
  // monitor pin
  output logic                             mon_out,
  output logic                             mon_oe,
  // lock/steer pins
  output logic                             lock_steer_primary_out,
  output logic                             lock_steer_primary_oe,
  output logic                             lock_steer_secondary_out,
  output logic                             lock_steer_secondary_oe
);

  //****************************************************************
  // link domain: shift registers on the serial clock
  //****************************************************************
  logic                      fresh_reg;
  logic [`SSP_WORD_BITS-1:0] data_sr_reg;
  logic [`SSP_WORD_BITS-1:0] mod_sr_reg;
  logic [`SSP_CNT_BITS-1:0]  bit_cnt_reg;
  logic                      frame_tog_reg;

  // set while chip select is high; the first clock of a frame sees it.
  // the serial clock may stand still between frames, so the clear is
  // done on that first edge rather than at the falling select edge
  // reset sets it too, so the first frame after power-up starts clean
  always_ff @(posedge link_sclk or posedge link_cs_n or posedge rst) begin
    if (link_cs_n || rst) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // word is kept after the frame so the core can read it stable
  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst) begin
      data_sr_reg <= `SSP_SR_RESET;
      mod_sr_reg  <= `SSP_SR_RESET;
      bit_cnt_reg <= '0;
      frame_tog_reg <= 1'b0;
    end else if (!link_cs_n) begin
      if (fresh_reg) begin
        frame_tog_reg <= ~frame_tog_reg;
        data_sr_reg <= {{(`SSP_WORD_BITS-1){1'b0}}, link_data};
        mod_sr_reg  <= {{(`SSP_WORD_BITS-1){1'b0}}, link_mod};
        bit_cnt_reg <= `SSP_CNT_BITS'(1);
      end else begin
        data_sr_reg <= {data_sr_reg[`SSP_WORD_BITS-2:0], link_data};
        mod_sr_reg  <= {mod_sr_reg[`SSP_WORD_BITS-2:0], link_mod};
        if (bit_cnt_reg != `SSP_CNT_MAX) begin
          bit_cnt_reg <= bit_cnt_reg + `SSP_CNT_BITS'(1);
        end
      end
    end
  end

  //****************************************************************
  // core domain: synchronised pins
  //****************************************************************
  logic [`SSP_SYNC_BITS-1:0] sync_q;
  logic                      cs_n_s;
  logic                      data_s;
  logic [1:0]                lock_err_s;
  logic [1:0]                steer_up_s;
  logic [1:0]                steer_dn_s;
  logic                      cs_n_prev_reg;
  logic                      cs_rise;
  logic                      tog_s;
  logic                      frame_ack_reg;
  logic                      new_frame;

  ssp_sync #(
    .W         (`SSP_SYNC_BITS),
    .RESET_VAL (`SSP_SYNC_RESET)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({frame_tog_reg, steer_dn, steer_up, lock_err, primary_compare_clock,
                secondary_compare_clock, ref_main_clk, ref_aux_clk,
                osc_clk, link_mod, link_data, link_cs_n}),
    .sync_out (sync_q)
  );

  assign cs_n_s     = sync_q[0];
  assign data_s     = sync_q[1];
  assign lock_err_s = sync_q[9:8];
  assign steer_up_s = sync_q[11:10];
  assign steer_dn_s = sync_q[13:12];
  assign tog_s      = sync_q[14];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_n_prev_reg <= 1'b1;
    end else begin
      cs_n_prev_reg <= cs_n_s;
    end
  end

  assign cs_rise = cs_n_s & ~cs_n_prev_reg;

  // a select pulse with no clock must not commit the previous word again
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_ack_reg <= 1'b0;
    end else if (cs_rise) begin
      frame_ack_reg <= tog_s;
    end
  end

  assign new_frame = cs_rise & (tog_s ^ frame_ack_reg);

  //****************************************************************
  // commit at the end of a frame
  //****************************************************************
  // sign-extend an n-bit sample held in the low bits
  function automatic logic [`SSP_DATA_BITS-1:0] sext(
    input logic [`SSP_WORD_BITS-1:0] sr,
    input logic [`SSP_CNT_BITS-1:0]  n
  );
    logic [`SSP_DATA_BITS-1:0] v;
    logic                      sgn;
    v   = '0;
    sgn = sr[4'(n - `SSP_CNT_BITS'(1))];
    for (int i = 0; i < `SSP_DATA_BITS; i++) begin
      v[i] = (i < int'(n)) ? sr[i] : sgn;
    end
    return v;
  endfunction : sext

  logic [`SSP_WORD_BITS-1:0] mod_word;
  logic                      full_word;
  logic                      short_word;

  // the shift registers ignore the serial clock while select is high, so these words are stable
  assign mod_word   = mod_src_sel ? mod_sr_reg : data_sr_reg;
  assign full_word  = (bit_cnt_reg == `SSP_FULL_BITS);
  assign short_word = (bit_cnt_reg >= `SSP_MOD_MIN_BITS) &&
                      (bit_cnt_reg <= `SSP_MOD_MAX_BITS);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_wr   <= 1'b0;
      cfg_addr <= `SSP_ADDR_RESET;
      cfg_data <= `SSP_DATA_RESET;
    end else begin
      cfg_wr <= 1'b0;
      if (new_frame && full_word && !mod_addr_off) begin
        cfg_wr   <= 1'b1;
        cfg_addr <= data_sr_reg[`SSP_ADDR_MSB:`SSP_ADDR_LSB];
        cfg_data <= data_sr_reg[`SSP_DATA_MSB:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mod_valid  <= 1'b0;
      mod_sample <= `SSP_DATA_RESET;
    end else begin
      mod_valid <= 1'b0;
      if (new_frame) begin
        if (mod_addr_off) begin
          if (short_word) begin
            mod_valid  <= 1'b1;
            mod_sample <= sext(mod_word, bit_cnt_reg);
          end
        end else if (full_word &&
                     mod_word[`SSP_ADDR_MSB:`SSP_ADDR_LSB] == `SSP_MOD_DATA_ADDR) begin
          mod_valid  <= 1'b1;
          mod_sample <= mod_word[`SSP_DATA_MSB:0];
        end
      end
    end
  end

  //****************************************************************
  // monitor output
  //****************************************************************
  logic mon_next;

  always_comb begin
    case (ssp_mon_sel_type'(mon_sel))
      SSP_MON_OSC:      mon_next = sync_q[3];
      SSP_MON_REF_AUX:  mon_next = sync_q[4];
      SSP_MON_REF_MAIN: mon_next = sync_q[5];
      SSP_MON_PD_AUX:   mon_next = sync_q[6];
      SSP_MON_PD_MAIN:  mon_next = sync_q[7];
      SSP_MON_LOOPBACK: mon_next = data_s;
      SSP_MON_TEST:     mon_next = ~cs_n_s;
      default:          mon_next = 1'b0;
    endcase
  end

  // sampled copies only: sources faster than half the core clock alias
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mon_out <= 1'b0;
      mon_oe  <= 1'b0;
    end else begin
      mon_out <= mon_next;
      mon_oe  <= ~mon_tristate;
    end
  end

  //****************************************************************
  // lock detect / steering pins
  //****************************************************************
  logic [1:0] ld_out_reg;
  logic [1:0] ld_oe_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ld_out_reg <= 2'h0;
      ld_oe_reg  <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ssp_ld_mode_type'(ld_mode[i]) == SSP_LD_STEER) begin
          ld_out_reg[i] <= steer_up_s[i] & ~steer_dn_s[i];
          ld_oe_reg[i]  <= steer_up_s[i] ^ steer_dn_s[i];
        end else begin
          ld_out_reg[i] <= 1'b0;
          ld_oe_reg[i]  <= lock_err_s[i];
        end
      end
    end
  end

  assign lock_steer_primary_out   = ld_out_reg[0];
  assign lock_steer_primary_oe    = ld_oe_reg[0];
  assign lock_steer_secondary_out = ld_out_reg[1];
  assign lock_steer_secondary_oe  = ld_oe_reg[1];

endmodule : ssp_port

// [ssp_port_checker.sv]
// assertions on the serial programming port
`timescale 1ns/1ps
module ssp_port_checker (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // inputs watched
  input wire logic       link_cs_n,
  input wire logic       mod_addr_off,
  input wire logic [2:0] mon_sel,
  input wire logic       mon_tristate,
  input wire logic [1:0] ld_mode,
  input wire logic [1:0] lock_err,
  // outputs watched
  input wire logic       cfg_wr,
  input wire logic       mod_valid,
  input wire logic       mon_out,
  input wire logic       mon_oe,
  input wire logic       lock_steer_primary_out,
  input wire logic       lock_steer_primary_oe,
  input wire logic       lock_steer_secondary_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  //****************************************************************
  // sequences
  //****************************************************************
  sequence s_addr_off;
    mod_addr_off [*8];
  endsequence
  sequence s_lock_mode;
    (!ld_mode[0] && $stable(lock_err[0])) [*8];
  endsequence
  //****************************************************************
  // properties
  //****************************************************************
  a_cfg_one_cycle: assert property (cfg_wr |=> !cfg_wr)
    else $error("cfg_wr longer than one cycle");
  a_mod_one_cycle: assert property (mod_valid |=> !mod_valid)
    else $error("mod_valid longer than one cycle");
  a_commit_after_rise: assert property (cfg_wr |-> link_cs_n && $past(link_cs_n, 4))
    else $error("commit without select rise");
  a_no_addressed_write: assert property (s_addr_off |-> !cfg_wr)
    else $error("addressed write while address is off");
  a_oe_follows_ctl: assert property (!$past(rst) |-> mon_oe == !$past(mon_tristate))
    else $error("monitor enable does not follow control");
  a_mon_code_seven: assert property ((mon_sel == 3'h7) [*6] |-> !mon_out)
    else $error("unused monitor code not low");
  a_lock_out_low: assert property ((!ld_mode[0]) [*8] |-> !lock_steer_primary_out)
    else $error("primary lock pin drives high");
  a_lock_sec_low: assert property ((!ld_mode[1]) [*8] |-> !lock_steer_secondary_out)
    else $error("secondary lock pin drives high");
  a_lock_oe_err: assert property (s_lock_mode |-> lock_steer_primary_oe == lock_err[0])
    else $error("primary lock pin enable wrong");
endmodule : ssp_port_checker

bind ssp_port ssp_port_checker chk (.core_clk(core_clk), .rst(rst), .link_cs_n(link_cs_n),
  .mod_addr_off(mod_addr_off), .mon_sel(mon_sel), .mon_tristate(mon_tristate),
  .ld_mode(ld_mode), .lock_err(lock_err), .cfg_wr(cfg_wr), .mod_valid(mod_valid),
  .mon_out(mon_out), .mon_oe(mon_oe), .lock_steer_primary_out(lock_steer_primary_out),
  .lock_steer_primary_oe(lock_steer_primary_oe),
  .lock_steer_secondary_out(lock_steer_secondary_out));

// [ssp_host.sv]
// host model driving the four-wire programming link
`timescale 1ns/1ps
module ssp_host (
  // link to the device
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_data,
  output logic link_mod
);
  initial begin
    {link_sclk, link_data, link_mod} = 3'h0;
    link_cs_n = 1'b1;
  end
  // n low bits of w, msb first; clock stands still outside frames
  task automatic send(input logic [15:0] w, input int n, input bit on_mod);
    #3 link_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      if (on_mod) link_mod = w[i];
      else link_data = w[i];
      #32 link_sclk = 1'b1;
      #32 link_sclk = 1'b0;
    end
    #20 link_cs_n = 1'b1;
    // released lines must not keep the last bit
    link_data = ~link_data;
    link_mod  = ~link_mod;
    #100;
  endtask : send
  // clock edges with select high, which must be ignored
  task automatic stray(input int n);
    repeat (n) begin
      #32 link_sclk = 1'b1;
      #32 link_sclk = 1'b0;
    end
  endtask : stray
endmodule : ssp_host

// [ssp_port_bench.sv]
// self-checking bench of the serial programming port
`timescale 1ns/1ps
module ssp_port_bench;
  logic        core_clk, rst, mod_addr_off, mod_src_sel, mon_tristate;
  logic [2:0]  mon_sel;
  logic [1:0]  ld_mode, lock_err, steer_up, steer_dn;
  logic [4:0]  src;
  logic        link_sclk, link_cs_n, link_data, link_mod;
  logic        cfg_wr, mod_valid, mon_out, mon_oe, lp_out, lp_oe, ls_out, ls_oe;
  logic [3:0]  cfg_addr;
  logic [11:0] cfg_data, got_mod;
  logic signed [11:0] mod_sample;
  logic [15:0] w, got_cfg;
  int          errors = 0, n_tests = 0, cfg_cnt = 0, mod_cnt = 0, seed, i, n;

  ssp_host host (.link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_data(link_data),
    .link_mod(link_mod));
  ssp_port dut (.core_clk(core_clk), .rst(rst), .link_sclk(link_sclk),
    .link_cs_n(link_cs_n), .link_data(link_data), .link_mod(link_mod),
    .mod_addr_off(mod_addr_off), .mod_src_sel(mod_src_sel), .mon_sel(mon_sel),
    .mon_tristate(mon_tristate), .ld_mode(ld_mode), .osc_clk(src[0]),
    .ref_aux_clk(src[1]), .ref_main_clk(src[2]), .secondary_compare_clock(src[3]),
    .primary_compare_clock(src[4]), .lock_err(lock_err), .steer_up(steer_up),
    .steer_dn(steer_dn), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .mod_valid(mod_valid), .mod_sample(mod_sample), .mon_out(mon_out), .mon_oe(mon_oe),
    .lock_steer_primary_out(lp_out), .lock_steer_primary_oe(lp_oe),
    .lock_steer_secondary_out(ls_out), .lock_steer_secondary_oe(ls_oe));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // pulses are one cycle wide, so they are caught here
  always @(posedge core_clk) begin
    if (cfg_wr === 1'b1) begin
      cfg_cnt++;
      got_cfg = {cfg_addr, cfg_data};
    end
    if (mod_valid === 1'b1) begin
      mod_cnt++;
      got_mod = mod_sample;
    end
  end
  //****************************************************************
  // compare, expectations, verdict
  //****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic results;
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  function automatic logic [11:0] sext(input logic [15:0] v, input int b);
    sext = v[11:0];
    for (int k = b; k < 12; k++) sext[k] = v[b-1];
  endfunction : sext
  function automatic logic mon_exp(input logic [2:0] s);
    if (s < 3'h5) return src[s];
    return (s == 3'h5) ? link_data : 1'b0;
  endfunction : mon_exp
  function automatic logic [1:0] pin_exp(input int k);
    if (!ld_mode[k]) return {lock_err[k], 1'b0};
    if (steer_up[k] ^ steer_dn[k]) return {1'b1, steer_up[k]};
    return 2'h0;
  endfunction : pin_exp
  // one frame, then the pulse counts it must have produced
  task automatic frame(input logic [15:0] v, input int b, input bit m, input int dc,
                       input int dm);
    int c0 = cfg_cnt;
    int m0 = mod_cnt;
    host.send(v, b, m);
    repeat (6) @(posedge core_clk);
    check(16'(cfg_cnt - c0), 16'(dc));
    check(16'(mod_cnt - m0), 16'(dm));
  endtask : frame

  initial begin
    #400000;
    errors++;
    results;
  end
  initial begin
    seed = 32'h39d1fe14;
    rst = 1'b0;
    #1 rst = 1'b1;
    {mod_addr_off, mod_src_sel, mon_tristate} = 3'h0;
    {mon_sel, ld_mode, lock_err, steer_up, steer_dn, src} = '0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    for (i = 0; i < 10; i++) begin
      w = (i == 0) ? 16'h5800 : (i == 1) ? 16'hFFFF : 16'($random(seed));
      if (i == 5) host.stray(4);
      if (i == 5) frame(w, 15, 1'b0, 0, 0);
      if (i == 6) frame(w, 0, 1'b0, 0, 0);
      frame(w, 16, 1'b0, 1, int'(w[15:12] == 4'h5));
      check(got_cfg, w);
      if (w[15:12] == 4'h5) check(got_mod, w[11:0]);
    end
    @(posedge core_clk);
    {mod_addr_off, mod_src_sel} <= 2'h3;
    for (i = 0; i < 10; i++) begin
      n = (i == 0) ? 2 : (i == 1) ? 12 : 2 + ($unsigned($random(seed)) % 11);
      w = 16'($random(seed));
      mod_src_sel <= !i[0];
      @(posedge core_clk);
      frame(w, n, !i[0], 0, 1);
      check(got_mod, sext(w, n));
    end
    frame(w, 13, 1'b1, 0, 0);
    frame(w, 16, 1'b1, 0, 0);
    @(posedge core_clk);
    mod_addr_off <= 1'b0;
    for (i = 0; i < 24; i++) begin
      @(posedge core_clk);
      mon_sel <= 3'(i);
      mon_tristate <= (i >= 16);
      src <= 5'($random(seed));
      repeat (9) @(posedge core_clk);
      check({mon_oe, mon_out & mon_oe}, {~mon_tristate, mon_exp(mon_sel) & ~mon_tristate});
    end
    for (i = 0; i < 24; i++) begin
      @(posedge core_clk);
      {ld_mode, lock_err, steer_up, steer_dn} <= 8'($random(seed));
      repeat (9) @(posedge core_clk);
      check({lp_oe, lp_out & lp_oe}, pin_exp(0));
      check({ls_oe, ls_out & ls_oe}, pin_exp(1));
    end
    results;
  end
endmodule : ssp_port_bench
